// *** rtl/fbp_pkg.sv ***
package fbp_pkg;
  // clock and flash strobe timing
  localparam int CLK_PERIOD_NS = 40;                  // 25 MHz system clock
  localparam int T_STROBE_NS   = 50;                  // least write strobe low time
  localparam int T_ACCESS_NS   = 70;                  // least output enable to data time
  localparam int STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC      = 2;                   // dq synchroniser depth
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] READ_CNT   = 4'(ACCESS_CYC + SYNC_CYC);
  // flash geometry
  localparam int FL_AW = 24;                          // word address width
  localparam int FL_DW = 16;                          // data width
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // control fields
  localparam int CTRL_ACCEL_BIT  = 8;
  localparam int CTRL_UNLOCK_BIT = 9;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_BYP  = 1;
  localparam int ST_DONE = 2;
  localparam int ST_PERR = 3;
  localparam int ST_AERR = 4;
  localparam int ST_REF  = 5;
  localparam int ST_ACC  = 6;
  // command words and unlock offsets
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_BYPASS  = 16'h0020;
  localparam logic [15:0] CMD_PSETUP  = 16'h00A0;
  localparam logic [15:0] CMD_EXIT1   = 16'h0090;
  localparam logic [15:0] CMD_EXIT2   = 16'h0000;
  localparam logic [15:0] CMD_RESET   = 16'h00F0;
  localparam logic [11:0] OFS_555     = 12'h555;
  localparam logic [11:0] OFS_2AA     = 12'h2AA;
  localparam logic [3:0]  ACCEL_LIMIT = 4'hA;         // accelerated uses per sector
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // operation codes written to the control register
  typedef enum logic [2:0] {OP_NONE, OP_ENTER, OP_PROG, OP_EXIT, OP_READ, OP_ABORT} fbp_op_t;
  // sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} fbp_seq_t;
  // bus cycle states
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fbp_cyc_t;
endpackage

// *** rtl/fbp_bus_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbp_bus_cycle (
  input  wire logic                        clk,     // system clock
  input  wire logic                        rst_n,   // async reset, low
  input  wire logic                        req,     // start one cycle
  input  wire logic                        isWrite, // write when high
  input  wire logic [fbp_pkg::FL_AW-1:0]   addr,    // word address
  input  wire logic [fbp_pkg::FL_DW-1:0]   wdata,   // write word
  output logic                             done,    // cycle finished pulse
  output logic [fbp_pkg::FL_DW-1:0]        rdata,   // captured read word
  output logic                             ceN,     // chip enable, low
  output logic                             weN,     // write strobe, low
  output logic                             oeN,     // output enable, low
  output logic [fbp_pkg::FL_AW-1:0]        flAddr,  // address pins
  output logic [fbp_pkg::FL_DW-1:0]        dqOut,   // data pin drive
  output logic                             dqOe,    // data pin enable, high drives
  input  wire logic [fbp_pkg::FL_DW-1:0]   dqIn     // data pin level
);
  import fbp_pkg::*;

  typedef struct packed {
    fbp_cyc_t           st;     // cycle phase
    logic [3:0]         cnt;    // phase counter
    logic               wr;     // current cycle is a write
    logic               done;
    logic [FL_DW-1:0]   rdata;
    logic               ceN, weN, oeN, dqOe;
    logic [FL_AW-1:0]   addr;
    logic [FL_DW-1:0]   dq;
    logic [FL_DW-1:0]   sync1;  // first synchroniser stage
    logic [FL_DW-1:0]   sync2;  // second synchroniser stage
  } fbp_cyc_state_t;

  fbp_cyc_state_t cur_ff;
  fbp_cyc_state_t nxt_cur;

  // one cycle: setup, strobe, hold, with the read sampled after sync
  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.done  = 1'b0;
    nxt_cur.sync1 = dqIn;
    nxt_cur.sync2 = cur_ff.sync1;
    case (cur_ff.st)
      BC_IDLE: begin
        if (req) begin
          nxt_cur.st   = BC_SETUP;
          nxt_cur.wr   = isWrite;
          nxt_cur.addr = addr;
          nxt_cur.dq   = wdata;
          nxt_cur.ceN  = 1'b0;
          nxt_cur.dqOe = isWrite;
        end
      end
      BC_SETUP: begin
        // strobe falls after address settled
        nxt_cur.st  = BC_STROBE;
        nxt_cur.weN = !cur_ff.wr;
        nxt_cur.oeN = cur_ff.wr;
        nxt_cur.cnt = cur_ff.wr ? STROBE_CNT : READ_CNT;
      end
      BC_STROBE: begin
        if (cur_ff.cnt > 4'h1) begin
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end else begin
          // write latches on rising strobe, read captured here
          nxt_cur.st  = BC_HOLD;
          nxt_cur.weN = 1'b1;
          nxt_cur.oeN = 1'b1;
          if (!cur_ff.wr) begin
            nxt_cur.rdata = cur_ff.sync2;
          end
        end
      end
      BC_HOLD: begin
        // release chip enable and bus
        nxt_cur.st   = BC_IDLE;
        nxt_cur.ceN  = 1'b1;
        nxt_cur.dqOe = 1'b0;
        nxt_cur.done = 1'b1;
      end
      default: begin
        nxt_cur.st = BC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{st: BC_IDLE, ceN: 1'b1, weN: 1'b1, oeN: 1'b1, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done   = cur_ff.done;
  assign rdata  = cur_ff.rdata;
  assign ceN    = cur_ff.ceN;
  assign weN    = cur_ff.weN;
  assign oeN    = cur_ff.oeN;
  assign flAddr = cur_ff.addr;
  assign dqOut  = cur_ff.dq;
  assign dqOe   = cur_ff.dqOe;
endmodule
`default_nettype wire

// *** rtl/fbp_host_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbp_host_ctrl #(
  parameter int AXI_AW = 8,                            // axi address width
  parameter int NSECT  = 16                            // tracked sectors
) (
  input  wire logic                        clk,        // system clock
  input  wire logic                        rst_n,      // async reset, low
  input  wire logic [AXI_AW-1:0]           awaddr,     // write address
  input  wire logic                        awvalid,    // write address valid
  output logic                             awready,    // write address ready
  input  wire logic [31:0]                 wdata,      // write data
  input  wire logic [3:0]                  wstrb,      // byte enables
  input  wire logic                        wvalid,     // write data valid
  output logic                             wready,     // write data ready
  output logic [1:0]                       bresp,      // write response
  output logic                             bvalid,     // write response valid
  input  wire logic                        bready,     // write response ready
  input  wire logic [AXI_AW-1:0]           araddr,     // read address
  input  wire logic                        arvalid,    // read address valid
  output logic                             arready,    // read address ready
  output logic [31:0]                      rdata,      // read data
  output logic [1:0]                       rresp,      // read response
  output logic                             rvalid,     // read data valid
  input  wire logic                        rready,     // read data ready
  output logic                             flashCeN,   // chip enable, low
  output logic                             flashWeN,   // write strobe, low
  output logic                             flashOeN,   // output enable, low
  output logic [fbp_pkg::FL_AW-1:0]        flashAddr,  // word address pins
  output logic [fbp_pkg::FL_DW-1:0]        flashDqOut, // data pin drive
  output logic                             flashDqOe,  // data pin enable
  input  wire logic [fbp_pkg::FL_DW-1:0]   flashDqIn,  // data pin level
  output logic                             accelerate_input // high voltage qualifier
);
  import fbp_pkg::*;

  localparam int SW = $clog2(NSECT);                   // sector index width

  typedef struct packed {
    logic                    awHeld, wHeld;            // halves of a write taken
    logic [AXI_AW-1:0]       awAddr;
    logic [31:0]             wData;
    logic                    awRdy, wRdy, arRdy;
    logic                    bValid, rValid;
    logic [1:0]              bResp, rResp;
    logic [31:0]             rData;
    fbp_seq_t                seq;                      // sequencer state
    fbp_op_t                 op;                       // running operation
    logic [1:0]              step;                     // write index in sequence
    logic                    cycReq;                   // bus cycle request pulse
    logic                    cycWr;
    logic [FL_AW-1:0]        cycAddr;
    logic [FL_DW-1:0]        cycData;
    logic [FL_AW-1:0]        addrReg;                  // target address
    logic [FL_DW-1:0]        dataReg;                  // program data
    logic [FL_DW-1:0]        rdWord;                   // last read result
    logic                    bypass, accel, unlocked, accelReq;
    logic                    confirm;                  // match seen, one more read
    logic                    togValid, prevTog;
    logic                    doneF, pollErr, abortErr, refused;
    logic [NSECT-1:0][3:0]   accelCnt;                 // accelerated uses per sector
  } fbp_host_state_t;

  fbp_host_state_t s_ff;
  fbp_host_state_t nxt_s;
  logic            cycDone;                            // bus cycle finished
  logic [FL_DW-1:0] cycRdata;                          // bus cycle read word

  // command table: address and word for each write of a sequence
  function automatic logic [FL_AW+FL_DW-1:0] cmdWord(input fbp_op_t op, input logic [1:0] step,
                                                      input logic [FL_AW-1:0] a, input logic [FL_DW-1:0] d);
    logic [FL_AW-1:0] bank;
    bank = {a[FL_AW-1:12], 12'h000};
    cmdWord = {a, d};
    case (op)
      OP_ENTER, OP_ABORT: begin
        // abort keeps all three writes
        // three unlock writes; abort ends in reset word
        if (step == 2'h0) cmdWord = {bank | FL_AW'(OFS_555), CMD_UNLOCK1};
        else if (step == 2'h1) cmdWord = {bank | FL_AW'(OFS_2AA), CMD_UNLOCK2};
        else cmdWord = {bank | FL_AW'(OFS_555), (op == OP_ENTER) ? CMD_BYPASS : CMD_RESET};
      end
      OP_PROG: begin
        // setup word, then data at target
        cmdWord = (step == 2'h0) ? {bank | FL_AW'(OFS_555), CMD_PSETUP} : {a, d};
      end
      OP_EXIT: begin
        cmdWord = (step == 2'h0) ? {bank, CMD_EXIT1} : {bank, CMD_EXIT2};
      end
      default: begin
        cmdWord = {a, d};
      end
    endcase
  endfunction

  // axi slave, register file and sequencer
  always_comb begin
    logic [5:0]        widx;
    logic [5:0]        ridx;
    logic [SW-1:0]     sect;
    logic [FL_DW-1:0]  d;
    logic              lastStep;
    widx = s_ff.awAddr[7:2];
    ridx = araddr[7:2];
    sect = s_ff.addrReg[FL_AW-1 -: SW];
    d = cycRdata;
    lastStep = 1'b0;
    nxt_s = s_ff;
    nxt_s.cycReq = 1'b0;
    // write channels taken in either order
    if (awvalid && s_ff.awRdy) begin
      nxt_s.awHeld = 1'b1;
      nxt_s.awAddr = awaddr;
    end
    if (wvalid && s_ff.wRdy) begin
      nxt_s.wHeld = 1'b1;
      nxt_s.wData = wdata;
    end
    if (bready && s_ff.bValid) begin
      nxt_s.bValid = 1'b0;
    end
    // both halves held: perform the register write
    if (s_ff.awHeld && s_ff.wHeld && !s_ff.bValid) begin
      nxt_s.awHeld = 1'b0;
      nxt_s.wHeld = 1'b0;
      nxt_s.bValid = 1'b1;
      nxt_s.bResp = RESP_OKAY;
      case ({widx, 2'b00})
        REG_ADDR: if (s_ff.seq == SQ_IDLE) nxt_s.addrReg = s_ff.wData[FL_AW-1:0];
        REG_DATA: if (s_ff.seq == SQ_IDLE) nxt_s.dataReg = s_ff.wData[FL_DW-1:0];
        REG_CTRL: begin
          nxt_s.unlocked = s_ff.wData[CTRL_UNLOCK_BIT];
          if (fbp_op_t'(s_ff.wData[2:0]) != OP_NONE) begin
            if (s_ff.seq != SQ_IDLE) begin
              nxt_s.refused = 1'b1;
            end else if ((fbp_op_t'(s_ff.wData[2:0]) == OP_ENTER && s_ff.bypass) ||
                         (fbp_op_t'(s_ff.wData[2:0]) == OP_PROG && !s_ff.bypass) ||
                         (fbp_op_t'(s_ff.wData[2:0]) == OP_EXIT && (!s_ff.bypass || s_ff.accel))) begin
              nxt_s.refused = 1'b1;
            end else if (fbp_op_t'(s_ff.wData[2:0]) == OP_PROG && s_ff.accel &&
                         s_ff.accelCnt[sect] >= ACCEL_LIMIT) begin
              nxt_s.refused = 1'b1;
            end else begin
              nxt_s.op = fbp_op_t'(s_ff.wData[2:0]);
              nxt_s.seq = SQ_ISSUE;
              nxt_s.step = 2'h0;
              nxt_s.doneF = 1'b0;
              nxt_s.pollErr = 1'b0;
              nxt_s.abortErr = 1'b0;
              nxt_s.refused = 1'b0;
              nxt_s.confirm = 1'b0;
              nxt_s.togValid = 1'b0;
              if (fbp_op_t'(s_ff.wData[2:0]) == OP_PROG && s_ff.accel) begin
                nxt_s.accelCnt[sect] = s_ff.accelCnt[sect] + 4'h1;
              end
            end
          end
          // accelerate needs unlock
          // checked last so a refusal outlives the clear of an accepted command
          if (s_ff.wData[CTRL_ACCEL_BIT] && !s_ff.wData[CTRL_UNLOCK_BIT]) nxt_s.refused = 1'b1;
          else nxt_s.accelReq = s_ff.wData[CTRL_ACCEL_BIT];
        end
        REG_STATUS: ;
        default: nxt_s.bResp = RESP_SLVERR;
      endcase
    end
    // read channel
    if (rready && s_ff.rValid) begin
      nxt_s.rValid = 1'b0;
    end
    if (arvalid && s_ff.arRdy) begin
      nxt_s.rValid = 1'b1;
      nxt_s.rResp = RESP_OKAY;
      nxt_s.rData = 32'h0000_0000;
      case ({ridx, 2'b00})
        REG_CTRL: nxt_s.rData = {22'h0, s_ff.unlocked, s_ff.accelReq, 5'h0, s_ff.op};
        REG_ADDR: nxt_s.rData = 32'(s_ff.addrReg);
        REG_DATA: nxt_s.rData = 32'(s_ff.dataReg);
        REG_STATUS: nxt_s.rData = {25'h0, s_ff.accel, s_ff.refused, s_ff.abortErr, s_ff.pollErr,
                                   s_ff.doneF, s_ff.bypass, s_ff.seq != SQ_IDLE};
        REG_RDATA: nxt_s.rData = 32'(s_ff.rdWord);
        default: nxt_s.rResp = RESP_SLVERR;
      endcase
    end
    // accelerate follows request only between operations
    if (s_ff.seq == SQ_IDLE && nxt_s.seq == SQ_IDLE && s_ff.accel != s_ff.accelReq) begin
      nxt_s.accel = s_ff.accelReq;
      // accelerate sets and clears short mode
      nxt_s.bypass = s_ff.accelReq;
    end
    // sequencer
    case (s_ff.seq)
      SQ_IDLE: ;
      SQ_ISSUE: begin
        nxt_s.cycReq = 1'b1;
        nxt_s.seq = SQ_WAIT;
        if (s_ff.op == OP_READ || s_ff.step == 2'h3) begin
          nxt_s.cycWr = 1'b0;
          nxt_s.cycAddr = s_ff.addrReg;
          nxt_s.cycData = '0;
        end else begin
          nxt_s.cycWr = 1'b1;
          {nxt_s.cycAddr, nxt_s.cycData} = cmdWord(s_ff.op, s_ff.step, s_ff.addrReg, s_ff.dataReg);
        end
      end
      SQ_WAIT: begin
        if (cycDone && s_ff.cycWr) begin
          lastStep = (s_ff.op == OP_ENTER || s_ff.op == OP_ABORT) ? (s_ff.step == 2'h2) : (s_ff.step == 2'h1);
          nxt_s.seq = SQ_ISSUE;
          if (!lastStep) begin
            nxt_s.step = s_ff.step + 2'h1;
          end else if (s_ff.op == OP_PROG) begin
            nxt_s.step = 2'h3;
          end else begin
            nxt_s.seq = SQ_IDLE;
            nxt_s.doneF = 1'b1;
            if (s_ff.op == OP_ENTER) nxt_s.bypass = 1'b1;
            if (s_ff.op == OP_EXIT) nxt_s.bypass = 1'b0;
          end
        end else if (cycDone) begin
          nxt_s.rdWord = d;
          nxt_s.seq = SQ_ISSUE;
          if (s_ff.op == OP_READ) begin
            nxt_s.seq = SQ_IDLE;
            nxt_s.doneF = 1'b1;
          end else if (d[7] == s_ff.dataReg[7]) begin
            // accept only on a second read
            if (s_ff.confirm) begin
              nxt_s.seq = SQ_IDLE;
              nxt_s.doneF = 1'b1;
            end
            nxt_s.confirm = 1'b1;
          end else if (d[1]) begin
            nxt_s.seq = SQ_IDLE;
            nxt_s.abortErr = 1'b1;
          end else if (s_ff.togValid && d[6] == s_ff.prevTog) begin
            nxt_s.seq = SQ_IDLE;
            nxt_s.pollErr = 1'b1;
          end else begin
            nxt_s.confirm = 1'b0;
            nxt_s.togValid = 1'b1;
            nxt_s.prevTog = d[6];
          end
        end
      end
      default: nxt_s.seq = SQ_IDLE;
    endcase
    nxt_s.awRdy = !nxt_s.awHeld && !nxt_s.bValid;
    nxt_s.wRdy = !nxt_s.wHeld && !nxt_s.bValid;
    nxt_s.arRdy = !nxt_s.rValid;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{seq: SQ_IDLE, op: OP_NONE, awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // flash pin cycle engine
  fbp_bus_cycle u_cycle (
    .clk     (clk),
    .rst_n   (rst_n),
    .req     (s_ff.cycReq),
    .isWrite (s_ff.cycWr),
    .addr    (s_ff.cycAddr),
    .wdata   (s_ff.cycData),
    .done    (cycDone),
    .rdata   (cycRdata),
    .ceN     (flashCeN),
    .weN     (flashWeN),
    .oeN     (flashOeN),
    .flAddr  (flashAddr),
    .dqOut   (flashDqOut),
    .dqOe    (flashDqOe),
    .dqIn    (flashDqIn)
  );

  assign awready = s_ff.awRdy;
  assign wready  = s_ff.wRdy;
  assign bvalid  = s_ff.bValid;
  assign bresp   = s_ff.bResp;
  assign arready = s_ff.arRdy;
  assign rvalid  = s_ff.rValid;
  assign rdata   = s_ff.rData;
  assign rresp   = s_ff.rResp;
  assign accelerate_input = s_ff.accel;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ENTER_THIRD: assert property (s_ff.cycReq && s_ff.cycWr && s_ff.op == OP_ENTER && s_ff.step == 2'h2 |->
    s_ff.cycData == CMD_BYPASS && s_ff.cycAddr[11:0] == OFS_555) else $error("bad bypass entry write");
  AST_BYPASS_AFTER: assert property ($rose(s_ff.bypass) && !s_ff.accel |->
    $past(s_ff.op) == OP_ENTER && $past(cycDone)) else $error("short mode set without entry");
  AST_PROG_SETUP: assert property (s_ff.cycReq && s_ff.cycWr && s_ff.op == OP_PROG |->
    (s_ff.step == 2'h0) ? s_ff.cycData == CMD_PSETUP : s_ff.cycData == s_ff.dataReg) else $error("bad program write");
  AST_EXIT_PAIR: assert property (s_ff.cycReq && s_ff.cycWr && s_ff.op == OP_EXIT |->
    s_ff.cycData == ((s_ff.step == 2'h0) ? CMD_EXIT1 : CMD_EXIT2)) else $error("bad exit write");
  AST_ABORT_FULL: assert property ($fell(s_ff.seq == SQ_IDLE) && s_ff.op == OP_ABORT |->
    ##[1:60] (s_ff.cycReq && s_ff.step == 2'h2 && s_ff.cycData == CMD_RESET)) else $error("short abort reset");
  AST_ACCEL_CAP: assert property (s_ff.accelCnt[s_ff.addrReg[FL_AW-1 -: SW]] <= ACCEL_LIMIT)
    else $error("too many accelerated uses");
  // unlock and request land on one edge, so look back a single cycle
  AST_ACCEL_UNLOCKED: assert property ($rose(accelerate_input) |-> $past(s_ff.unlocked))
    else $error("accelerate raised while locked");
  AST_POLL_ADDR: assert property (s_ff.cycReq && !s_ff.cycWr && s_ff.op == OP_PROG |->
    s_ff.cycAddr == s_ff.addrReg) else $error("poll off target");
  AST_CONFIRM: assert property ($rose(s_ff.doneF) && s_ff.op == OP_PROG |-> $past(s_ff.confirm))
    else $error("done without confirming read");
  AST_TOGGLE_STOP: assert property (cycDone && !s_ff.cycWr && s_ff.op == OP_PROG && s_ff.seq == SQ_WAIT &&
    s_ff.togValid && cycRdata[6] == s_ff.prevTog && cycRdata[7] != s_ff.dataReg[7] && !cycRdata[1] |=> s_ff.pollErr)
    else $error("stopped toggle missed");
  AST_ABORT_FLAG: assert property (cycDone && !s_ff.cycWr && s_ff.op == OP_PROG && s_ff.seq == SQ_WAIT &&
    cycRdata[1] && cycRdata[7] != s_ff.dataReg[7] |=> s_ff.abortErr) else $error("abort bit missed");

  COV_ENTER: cover property ($rose(s_ff.bypass));
  COV_POLL_ERR: cover property ($rose(s_ff.pollErr));
  COV_PROG_DONE: cover property ($rose(s_ff.doneF) && s_ff.op == OP_PROG);
  COV_ABORT_ERR: cover property ($rose(s_ff.abortErr));
endmodule
`default_nettype wire

// *** testbench/fbp_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_model (
  input  wire logic        ceN,   // chip enable, low
  input  wire logic        weN,   // write strobe, low
  input  wire logic        oeN,   // output enable, low
  input  wire logic [23:0] addr,  // word address
  input  wire logic [15:0] dqOut, // host data drive
  input  wire logic        dqOe,  // host drives dq
  input  wire logic        accel, // high voltage qualifier
  input  wire logic [1:0]  fault, // 1 stuck toggle, 2 abort
  output logic      [15:0] dqIn,  // dq wire level
  output logic             inByp  // short mode seen
);
  logic        byp = 0, pnd = 0, arm = 0, tog = 0, abt = 0; // mode flags
  logic [1:0]  stp = 0;                                     // unlock step
  logic [3:0]  bsy = 0;                                     // busy polls left
  logic [15:0] mem = 16'hFFFF, lst = 16'h0000, rv;          // word, last, read
  assign inByp = byp | accel;
  assign rv = (bsy != 0) ? {8'h00, ~mem[7], tog, 4'h0, abt, 1'b0} : mem;
  // released bus shows inverse of last word
  assign dqIn = dqOe ? dqOut : (!ceN && !oeN) ? rv : ~lst;
  always @(posedge oeN) begin
    lst <= rv;
    if (fault != 2'h1) tog <= ~tog;
    if (fault == 2'h0 && bsy != 0) bsy <= bsy - 4'h1;
  end
  always @(posedge weN) if (!ceN) begin
    stp <= 2'h0;
    if (pnd) begin
      // top sector protected: status only, word kept
      mem <= (addr[23:20] == 4'hF) ? mem : dqOut; bsy <= (fault == 2'h2) ? 4'hF : 4'h3; abt <= fault == 2'h2; pnd <= 0;
    end else if (inByp && dqOut == 16'h00A0) pnd <= 1;
    else if (inByp && dqOut == 16'h0090) arm <= 1;
    else if (arm && dqOut == 16'h0000) begin byp <= 0; arm <= 0; end
    else if (dqOut == 16'h00AA && addr[11:0] == 12'h555) stp <= 2'h1;
    else if (stp == 2'h1 && dqOut == 16'h0055 && addr[11:0] == 12'h2AA) stp <= 2'h2;
    else if (stp == 2'h2 && dqOut == 16'h0020 && addr[11:0] == 12'h555) byp <= 1;
    else if (stp == 2'h2 && dqOut == 16'h00F0) begin abt <= 0; bsy <= 4'h0; end
  end
endmodule
`default_nettype wire

// *** testbench/flash_bypass_accel_poll_status_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_bypass_accel_poll_status_test;
  import fbp_pkg::*;
  typedef struct packed {logic [31:0] c; logic [23:0] a; logic [15:0] d; int b; logic e, y;} fbp_row_t;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;   // bus addresses
  logic [31:0] wdata = 0, rd, st, rdata; // bus data
  logic [1:0]  fault = 0, resp, bresp, rresp;
  logic        flashCeN, flashWeN, flashOeN, flashDqOe, accelerate_input, byp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [23:0] flashAddr;
  logic [15:0] flashDqOut, flashDqIn;
  int          fails = 0, samples_checked = 0;
  fbp_row_t rows [7] = '{'{32'h2, 24'h001000, 16'h1234, ST_REF, 1'h1, 1'h0},
    '{32'h1, 24'h001000, 16'h0000, ST_BYP, 1'h1, 1'h1}, '{32'h1, 24'h001000, 16'h0000, ST_REF, 1'h1, 1'h1},
    '{32'h2, 24'h001234, 16'h5A5A, ST_DONE, 1'h1, 1'h1}, '{32'h4, 24'h001234, 16'h0000, ST_PERR, 1'h0, 1'h1},
    '{32'h3, 24'h001000, 16'h0000, ST_BYP, 1'h0, 1'h0}, '{32'h3, 24'h001000, 16'h0000, ST_REF, 1'h1, 1'h0}};
  initial forever #20 clk = ~clk;
  fbp_host_ctrl dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .flashCeN,
    .flashWeN, .flashOeN, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .accelerate_input);
  fbp_flash_model flash (.ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN), .addr(flashAddr), .dqOut(flashDqOut),
    .dqOe(flashDqOe), .accel(accelerate_input), .fault, .dqIn(flashDqIn), .inByp(byp));
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin $display("wrong value %s expected %h seen %h", n, e, g); fails++; end
  endtask
  task hang(input int i);
    if (i >= 300) begin fails++; end_of_test; end
  endtask
  // write: address and data together, bready held until response
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk); awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (i = 0; i < 300; i++) begin
      @(posedge clk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; if (bvalid) break;
    end
    resp = bresp; bready <= 0; hang(i);
  endtask
  // read: rready held until data arrives
  task rdr(input logic [7:0] a);
    int i;
    @(posedge clk); araddr <= a; arvalid <= 1; rready <= 1;
    for (i = 0; i < 300; i++) begin @(posedge clk); if (arready) arvalid <= 0; if (rvalid) break; end
    rd = rdata; resp = rresp; rready <= 0; hang(i);
  endtask
  // issue one command and poll until idle
  task op(input logic [23:0] a, input logic [15:0] d, input logic [31:0] c);
    int i;
    wr(REG_ADDR, {8'h00, a}); wr(REG_DATA, {16'h0000, d}); wr(REG_CTRL, c);
    for (i = 0; i < 300; i++) begin rdr(REG_STATUS); if (rd[ST_BUSY] === 1'b0) break; end
    st = rd; hang(i);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    chk("ce idle", 32'h1, flashCeN); chk("accel idle", 32'h0, accelerate_input);
    rdr(REG_STATUS); chk("status reset", 32'h0, rd[6:0]);
    wr(8'h14, 32'h1); chk("bresp", RESP_SLVERR, resp);
    rdr(8'h14); chk("rresp", RESP_SLVERR, resp);
    foreach (rows[k]) begin
      op(rows[k].a, rows[k].d, rows[k].c);
      chk("status bit", rows[k].e, st[rows[k].b]);
      chk("mode", rows[k].y, byp);
    end
    rdr(REG_RDATA); chk("rdata", 32'h5A5A, rd);
    op(24'h100000, 16'h0000, 32'h100); chk("no unlock", 32'h1, st[ST_REF]);
    chk("no accel", 32'h0, st[ST_ACC]);
    op(24'h100000, 16'h0000, 32'h300); chk("accel pin", 32'h1, accelerate_input);
    chk("accel mode", 32'h1, st[ST_ACC] & st[ST_BYP] & byp);
    op(24'h100000, 16'h0000, 32'h303); chk("exit accel", 32'h1, st[ST_REF]);
    chk("still short", 32'h1, st[ST_BYP]);
    fault <= 2'h1;
    op(24'h100040, 16'h00C3, 32'h302); chk("poll err", 32'h1, st[ST_PERR]);
    fault <= 2'h2;
    op(24'h100042, 16'h00C3, 32'h302); chk("abort err", 32'h1, st[ST_AERR]);
    fault <= 2'h0;
    op(24'h100000, 16'h0000, 32'h305);
    op(24'h100044, 16'h00C3, 32'h302); chk("after abort", 32'h1, st[ST_DONE]);
    op(24'hF00000, 16'h00AA, 32'h302); chk("prot done", 32'h1, st[ST_DONE]);
    op(24'hF00000, 16'h0000, 32'h304); rdr(REG_RDATA); chk("prot data", 32'h00C3, rd);
    op(24'h100000, 16'h0000, 32'h200); chk("drop", 32'h0, {accelerate_input, byp, st[ST_BYP]});
    end_of_test;
  end
endmodule
`default_nettype wire
